//--- rtl/encsim_defs.svh
/*
 * Constants for the encoder pulse simulator: widths, limits, reset
 * values and timing counts. Included by the simulator core only;
 * assumes a 50 MHz core clock.
 */
`ifndef ENCSIM_DEFS_SVH
`define ENCSIM_DEFS_SVH

`define ENCSIM_POS_W        16
`define ENCSIM_OFS_W        15
`define ENCSIM_OFS_RST      15'sh0005
`define ENCSIM_OFS_MAX      15'sh2000
`define ENCSIM_OFS_MIN      15'sh6001
`define ENCSIM_LINE_SEL_W   4
`define ENCSIM_LINE_SEL_MAX 4'hb
`define ENCSIM_LINE_SEL_RST 4'h5
`define ENCSIM_SHIFT_BASE   5'h0d
`define ENCSIM_CLK_HZ       50000000
`define ENCSIM_TICK_NS      100
`define ENCSIM_TICK_CYC     ((`ENCSIM_TICK_NS * (`ENCSIM_CLK_HZ / 1000000)) / 1000)
`define ENCSIM_TICK_W       8
`define ENCSIM_ZP_NS        1000
`define ENCSIM_ZP_CYC       ((`ENCSIM_ZP_NS * (`ENCSIM_CLK_HZ / 1000000)) / 1000)

`endif

//--- rtl/encsim_pkg.sv
/*
 * Types of the encoder pulse simulator. Used by the simulator core only.
 */
package encsim_pkg;
    typedef enum logic {ENCSIM_MODE_PASS, ENCSIM_MODE_SCALED} encsim_mode_t;
    typedef enum logic [1:0] {ENCSIM_ZP_IDLE, ENCSIM_ZP_ARMED, ENCSIM_ZP_COUNT,
                              ENCSIM_ZP_FIRE} encsim_zp_state_t;
endpackage

//--- rtl/encsim_quad_step.sv
/*
 * Quadrature stepper: one step pulse with a direction moves a 2-bit
 * binary phase, gray-decoded into tracks A and B from flip-flops. Assumes step pulses
 * are already paced by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
module encsim_quad_step (
    input  wire logic core_clk,   // Core clock
    input  wire logic sys_rst,    // Async reset, high
    input  wire logic step,       // One-cycle step request
    input  wire logic dir_cw,     // 1 = clockwise step
    output logic      trk_a,      // Track A
    output logic      trk_b,      // Track B
    output logic      period_end  // Pulse when phase wraps to 0
);
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    wire        do_wrap;

    // Clockwise counts up, so A leads B; the reverse swaps order
    assign phase_nxt = dir_cw ? phase_r + 2'h1 : phase_r - 2'h1;
    assign do_wrap   = step && (phase_nxt == 2'h0);

    // ==============================================================
    // Phase and tracks
    // Gray decode keeps A and B a quarter period apart
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r    <= 2'h0;
            trk_a      <= 1'b0;
            trk_b      <= 1'b0;
            period_end <= 1'b0;
        end else begin
            period_end <= do_wrap;
            if (step) begin
                phase_r <= phase_nxt;
                trk_a   <= phase_nxt[1] ^ phase_nxt[0];
                trk_b   <= phase_nxt[1];
            end
        end
    end

    a_quarter_shift: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(trk_a) |-> $stable(trk_b)) else $error("tracks changed together");
    a_wrap_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
        do_wrap |=> period_end) else $error("period end missing");
endmodule
`default_nettype wire

//--- rtl/encsim_core.sv
/*
 * Encoder pulse simulator core. Pass-through synchronises and forwards the
 * optical tracks; scaled mode steps quadrature outputs from the
 * motor angle at a chosen power-of-two line count and places a zero
 * pulse a nonzero signed number of periods after the angle zero crossing.
 * Assumes the angle word comes from the core clock domain and the
 * analogue tracks and sync input come from pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "encsim_defs.svh"
module encsim_core (
    input  wire logic                          core_clk,                 // 50 MHz clock
    input  wire logic                          sys_rst,                  // Async reset, high
    input  wire logic                          mode_scaled,              // 1 = scaled software mode
    input  wire logic                          enc_optical,              // Optical encoder fitted
    input  wire logic [`ENCSIM_LINE_SEL_W-1:0] line_sel,                 // Lines = 32 << sel
    input  wire logic signed [`ENCSIM_OFS_W-1:0] zero_pulse_offset_periods, // Signed offset
    input  wire logic                          ofs_load,                 // Load offset pulse
    input  wire logic                          zero_pulse_sim_select,    // Pin: low = enable
    input  wire logic [`ENCSIM_POS_W-1:0]      motor_angle,              // Angle, full turn
    input  wire logic                          sin_sq,                   // Comparator sine
    input  wire logic                          cos_sq,                   // Comparator cosine
    input  wire logic                          sin_index,                // Optical index mark
    output logic                               out_a,                    // Track A
    output logic                               out_b,                    // Track B
    output logic                               out_z,                    // Zero pulse track
    output logic signed [`ENCSIM_OFS_W-1:0]    ofs_active,               // Offset in use
    output logic                               zp_armed                  // Waiting to emit
);
    // ==============================================================
    // Pin synchronisers
    logic [1:0] sin_s_r, cos_s_r, idx_s_r, sync_s_r;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sin_s_r  <= 2'h0;
            cos_s_r  <= 2'h0;
            idx_s_r  <= 2'h0;
            sync_s_r <= 2'h3;
        end else begin
            sin_s_r  <= {sin_s_r[0], sin_sq};
            cos_s_r  <= {cos_s_r[0], cos_sq};
            idx_s_r  <= {idx_s_r[0], sin_index};
            sync_s_r <= {sync_s_r[0], zero_pulse_sim_select};
        end
    end

    // ==============================================================
    // Offset register, kept within its legal range
    logic signed [`ENCSIM_OFS_W-1:0] ofs_r;
    wire ofs_ok = (zero_pulse_offset_periods <= `ENCSIM_OFS_MAX)
               && (zero_pulse_offset_periods >= `ENCSIM_OFS_MIN);
    // Out-of-range writes are dropped rather than wrapped
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            ofs_r <= `ENCSIM_OFS_RST;
        else if (ofs_load && ofs_ok)
            ofs_r <= zero_pulse_offset_periods;
    end
    assign ofs_active = ofs_r;

    // ==============================================================
    // Line count scaling: target position in quarter steps
    logic [`ENCSIM_LINE_SEL_W-1:0] sel_r;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            sel_r <= `ENCSIM_LINE_SEL_RST;
        else if (line_sel <= `ENCSIM_LINE_SEL_MAX)
            sel_r <= line_sel;
    end
    // Angle sampled once per tick; the update rate is the small lag
    logic [7:0] tick_cnt_r;
    wire        tick = (tick_cnt_r == 8'(`ENCSIM_TICK_CYC - 1));
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            tick_cnt_r <= 8'h00;
        else
            tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
    end
    logic [`ENCSIM_POS_W-1:0] ang_r;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            ang_r <= '0;
        else if (tick)
            ang_r <= motor_angle;
    end
    // Quarter-step position: angle * 4 * 32 << sel / 2^16, kept 20 bits wide
    wire [4:0]  shr = `ENCSIM_SHIFT_BASE - 5'(sel_r);
    wire [19:0] tgt = 20'({ang_r, 4'h0} >> shr);
    // Quarter steps per turn less one, and half a turn, for modular distance
    wire [19:0] top_q  = (20'h80 << sel_r) - 20'h1;
    wire [19:0] half_q = 20'h40 << sel_r;
    logic [19:0] pos_r;
    // Distance taken modulo one turn, so the wrap through zero is one step
    wire [19:0] diff = (tgt - pos_r) & top_q;
    wire        need_step = (diff != 20'h0);
    wire        step_cw = ((diff & half_q) == 20'h0);
    // Masking keeps position inside the turn after a line count change
    wire [19:0] pos_inc = (pos_r + 20'h1) & top_q;
    wire [19:0] pos_dec = (pos_r - 20'h1) & top_q;
    // One quarter step per cycle at most; the configurer keeps speed low
    wire        step = mode_scaled && need_step;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            pos_r <= '0;
        else if (step)
            pos_r <= step_cw ? pos_inc : pos_dec;
    end

    logic q_a, q_b, q_wrap;
    encsim_quad_step u_quad (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .step       (step),
        .dir_cw     (step_cw),
        .trk_a      (q_a),
        .trk_b      (q_b),
        .period_end (q_wrap)
    );

    // ==============================================================
    // Zero pulse placement
    // Revolution mark: position wraps through zero, direction known
    wire cross_cw  = step && step_cw  && (pos_r == top_q);
    // Period end seen on the step itself, so the mark's own wrap is not counted
    wire per_end = step && (step_cw ? (pos_r[1:0] == 2'h3) : (pos_r[1:0] == 2'h1));
    wire cross_ccw = step && !step_cw && (pos_r == 20'h0);
    wire sim_en = mode_scaled && enc_optical && !sync_s_r[1];
    wire want_cw = !ofs_r[`ENCSIM_OFS_W-1];
    wire [`ENCSIM_OFS_W-1:0] ofs_mag = want_cw ? ofs_r : -ofs_r;
    wire period_dir_ok = (step_cw == want_cw);

    encsim_pkg::encsim_zp_state_t st_r;
    logic [`ENCSIM_OFS_W-1:0] per_cnt_r;
    logic [5:0]               zp_cnt_r;
    wire dir_cross = want_cw ? cross_cw : cross_ccw;
    // Same mark every turn, so placement repeats
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r      <= encsim_pkg::ENCSIM_ZP_IDLE;
            per_cnt_r <= '0;
            zp_cnt_r  <= 6'h00;
        end else begin
            case (st_r)
                encsim_pkg::ENCSIM_ZP_IDLE: begin
                    if (sim_en && dir_cross && ofs_mag != '0) begin
                        st_r      <= encsim_pkg::ENCSIM_ZP_COUNT;
                        per_cnt_r <= ofs_mag;
                    end
                end
                encsim_pkg::ENCSIM_ZP_COUNT: begin
                    // Reversal or disable abandons the pulse
                    if (!sim_en || (step && !period_dir_ok))
                        st_r <= encsim_pkg::ENCSIM_ZP_IDLE;
                    else if (per_end) begin
                        if (per_cnt_r == 15'h0001) begin
                            st_r     <= encsim_pkg::ENCSIM_ZP_FIRE;
                            zp_cnt_r <= 6'(`ENCSIM_ZP_CYC);
                        end
                        per_cnt_r <= per_cnt_r - 15'h0001;
                    end
                end
                encsim_pkg::ENCSIM_ZP_FIRE: begin
                    zp_cnt_r <= zp_cnt_r - 6'h01;
                    if (zp_cnt_r == 6'h01)
                        st_r <= encsim_pkg::ENCSIM_ZP_IDLE;
                end
                default: st_r <= encsim_pkg::ENCSIM_ZP_IDLE;
            endcase
        end
    end
    assign zp_armed = (st_r == encsim_pkg::ENCSIM_ZP_COUNT);
    wire zp_sw = (st_r == encsim_pkg::ENCSIM_ZP_FIRE);

    // ==============================================================
    // Output selection, registered
    wire nxt_a = mode_scaled ? q_a : sin_s_r[1];
    wire nxt_b = mode_scaled ? q_b : cos_s_r[1];
    // No zero track in scaled mode unless simulation runs
    wire nxt_z = mode_scaled ? zp_sw : idx_s_r[1];
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_a <= 1'b0;
            out_b <= 1'b0;
            out_z <= 1'b0;
        end else begin
            out_a <= nxt_a;
            out_b <= nxt_b;
            out_z <= nxt_z;
        end
    end

    // ==============================================================
    // Checks
    a_zp_only_en: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode_scaled && $past(mode_scaled) && $rose(out_z)) |-> $past(sim_en, 2))
        else $error("zero pulse while disabled");
    a_period_sync: assert property (@(posedge core_clk) disable iff (sys_rst)
        per_end |=> q_wrap) else $error("period count out of step");
    a_sync_high_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        sync_s_r[1] |=> st_r != encsim_pkg::ENCSIM_ZP_COUNT)
        else $error("sync high kept armed");
    a_ofs_range: assert property (@(posedge core_clk) disable iff (sys_rst)
        ofs_r <= `ENCSIM_OFS_MAX && ofs_r >= `ENCSIM_OFS_MIN)
        else $error("offset out of range");
    a_wrong_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
        (zp_armed && step && !period_dir_ok) |=> !zp_armed && !zp_sw)
        else $error("wrong direction kept pulse");
    a_count_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        (st_r == encsim_pkg::ENCSIM_ZP_IDLE && sim_en && dir_cross && ofs_mag != '0)
        |=> per_cnt_r == $past(ofs_mag)) else $error("offset not loaded");
    a_pass_fwd: assert property (@(posedge core_clk) disable iff (sys_rst)
        !mode_scaled |=> out_a == $past(sin_s_r[1]) && out_b == $past(cos_s_r[1]))
        else $error("pass-through mismatch");
    a_zp_width: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(zp_sw) |-> zp_sw [*8]) else $error("zero pulse too short");
    a_scaled_lag: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick |=> ang_r == $past(motor_angle)) else $error("angle not sampled");
    a_step_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
        step |=> pos_r != $past(pos_r)) else $error("step lost");
endmodule
`default_nettype wire

//--- tb/encsim_ctrl_model.sv
/*
 * Controller-side model: decodes tracks A and B into a signed quarter-step
 * count, counts every zero pulse and keeps the count where each of the last two arrived.
 * Assumes tracks come from the simulator core on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module encsim_ctrl_model (
    input  wire logic core_clk,  // Clock
    input  wire logic sys_rst,   // Reset, high
    input  wire logic out_a,     // Track A
    input  wire logic out_b,     // Track B
    input  wire logic out_z,     // Zero pulse track
    output int        pos,       // Quarter steps, cw positive
    output int        z_cnt,     // Zero pulses seen
    output int        z_pa,      // Count at last zero pulse
    output int        z_pb,      // Count at the one before
    output int        bad_steps  // Both tracks moved at once
);
    logic [1:0] ph_r;
    logic       z_r;
    // Gray phase 00,10,11,01 of {A,B} runs cw, so A leads B
    wire  [1:0] ph = {out_b, out_a ^ out_b};
    wire  [1:0] d  = ph - ph_r;

    // =======================================
    // Counter, like a real controller input
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ph_r <= 2'h0;
            z_r <= 1'b0;
            pos <= 0;
            z_cnt <= 0;
            z_pa <= 0;
            z_pb <= 0;
            bad_steps <= 0;
        end else begin
            ph_r <= ph;
            z_r <= out_z;
            if (d == 2'h1) pos <= pos + 1;
            if (d == 2'h3) pos <= pos - 1;
            // A half-period jump cannot be counted: lost step
            if (d == 2'h2) bad_steps <= bad_steps + 1;
            if (out_z && !z_r) begin
                z_cnt <= z_cnt + 1;
                z_pa <= pos;
                z_pb <= z_pa;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/encoder_pulse_simulator_test.sv
/*
 * Bench for the encoder pulse simulator core: rotation rows, offset limits
 * and pass-through. Assumes the controller model is compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module encoder_pulse_simulator_test;
    typedef struct {int ls, ofs, ccw, hi, opt, step, nz;} encsim_row_t;
    logic               core_clk, sys_rst, mode_scaled, enc_optical, ofs_load, sel, sin_sq, cos_sq;
    logic               sin_idx;
    logic [3:0]         line_sel;
    logic signed [14:0] ofs;
    logic [15:0]        motor_angle;
    wire                out_a, out_b, out_z, zp_armed;
    wire signed [14:0]  ofs_active;
    int                 pos, z_cnt, z_pa, z_pb, bad_steps, miscompares, compares, k;
    // Steps keep tracks below 500 kHz at these line counts
    encsim_row_t rows[7] = '{'{0, 2, 0, 0, 1, 16, 2}, '{1, 5, 0, 0, 1, 8, 2},
        '{0, -3, 1, 0, 1, 16, 2}, '{0, -3, 0, 0, 1, 16, 0}, '{0, 2, 0, 1, 1, 16, 0},
        '{0, 2, 0, 0, 0, 16, 0}, '{0, 0, 0, 0, 1, 16, 0}};

    encsim_core encsim_core_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .mode_scaled(mode_scaled), .enc_optical(enc_optical), .line_sel(line_sel),
        .zero_pulse_offset_periods(ofs), .ofs_load(ofs_load), .zero_pulse_sim_select(sel),
        .motor_angle(motor_angle), .sin_sq(sin_sq), .cos_sq(cos_sq), .sin_index(sin_idx),
        .out_a(out_a), .out_b(out_b), .out_z(out_z), .ofs_active(ofs_active),
        .zp_armed(zp_armed));
    encsim_ctrl_model encsim_ctrl_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .out_a(out_a), .out_b(out_b), .out_z(out_z), .pos(pos), .z_cnt(z_cnt),
        .z_pa(z_pa), .z_pb(z_pb), .bad_steps(bad_steps));

    // ==========
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ==========
    // Helpers; inputs always move 1 ns after the rising edge
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %0d seen %0d", what, $signed(exp), $signed(seen));
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Angle is set under reset; the row lets the core walk to it before taking p0
    task automatic do_reset(logic [15:0] ang);
        sys_rst = 1'b1;
        motor_angle = ang;
        repeat (20) tick();
        sys_rst = 1'b0;
        repeat (4) tick();
    endtask
    task automatic load(int v);
        ofs = v[14:0];
        ofs_load = 1'b1;
        tick();
        ofs_load = 1'b0;
        repeat (2) tick();
    endtask
    // One row: 2.25 turns, two zero crossings, then bounded settle
    task automatic run_row(encsim_row_t r);
        int q, p0, n, i, want;
        q = (128 << r.ls) * (r.ccw ? -1 : 1);
        do_reset(r.ccw ? 16'he000 : 16'h2000);
        mode_scaled = 1'b1;
        line_sel = r.ls[3:0];
        enc_optical = r.opt[0];  // Zero pulse simulation only runs with optical
        sel = r.hi[0];
        load(r.ofs);
        repeat (40) tick();
        p0 = pos;
        n = z_cnt;
        for (i = 0; i < 'h24000 / r.step; i++) begin
            motor_angle = r.ccw ? motor_angle - r.step[15:0] : motor_angle + r.step[15:0];
            tick();
        end
        want = p0 + q * 9 / 4;
        for (i = 0; i < 400 && pos != want; i++) tick();
        check("quarter steps", pos, want);
        if (pos != want) finish_test();
        repeat (60) tick();
        check("lost steps", bad_steps, 0);
        check("zero pulses", z_cnt - n, r.nz);
        if (r.nz == 2) check("zero spacing", z_pa - z_pb, q);
        $display("Row ls=%0d ofs=%0d ccw=%0d done", r.ls, r.ofs, r.ccw);
    endtask

    // ==========
    // Main sequence
    initial begin
        {mode_scaled, enc_optical, ofs_load, sel, sin_sq, cos_sq} = 6'h00;
        sin_idx = 1'b0;
        line_sel = 4'h0;
        ofs = 15'sh0000;
        do_reset(16'h0000);
        check("ofs_active", ofs_active, 5);
        check("zp_armed", zp_armed, 0);
        check("out_z", out_z, 0);
        $display("Reset test done");
        foreach (rows[i]) run_row(rows[i]);
        // Offset limits: outside values keep the last legal one
        do_reset(16'h0000);
        load(8192);
        check("ofs_active", ofs_active, 8192);
        load(8193);
        check("ofs_active", ofs_active, 8192);
        load(-8191);
        check("ofs_active", ofs_active, -8191);
        load(-8192);
        check("ofs_active", ofs_active, -8191);
        $display("Offset limit test done");
        // Pass-through: squared tracks walked one cw period twice
        mode_scaled = 1'b0;
        repeat (10) tick();
        for (k = 0; k < 8; k++) begin
            {sin_sq, cos_sq} = 8'h2d >> (6 - 2 * ((k + 1) % 4));
            sin_idx = (k % 4 == 3);
            repeat (5) tick();
            check("tracks", {out_a, out_b}, {sin_sq, cos_sq});
            check("index", out_z, sin_idx);
        end
        check("pass steps", pos, 8);
        $display("Pass-through test done");
        finish_test();
    end
endmodule
`default_nettype wire
